// ===== fbc_pkg.sv
// Shared constants and types for the byte-mode flash command host.
package fbc_pkg;
  localparam int ADDR_W = 22;
  localparam logic [11:0] ADR_UNLOCK1 = 12'haaa;
  localparam logic [11:0] ADR_UNLOCK2 = 12'h555;
  localparam logic [7:0] DAT_UNLOCK1 = 8'haa;
  localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_AUTOSEL = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_SECTOR = 8'h30;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_PSUSPEND = 8'h51;
  localparam logic [7:0] CMD_PRESUME = 8'h50;
  localparam logic [7:0] CMD_EXIT = 8'h00;
  localparam logic [7:0] CMD_PWD_ENTRY = 8'h60;
  localparam logic [7:0] OFS_PROTECT = 8'h04;
  localparam logic [7:0] OFS_SECURE = 8'h06;
  localparam logic [7:0] OFS_PASSWORD0 = 8'h00;
  localparam logic [7:0] OFS_PASSWORD3 = 8'h03;
  localparam logic [3:0] STROBE_LOW_CYC = 4'h3;
  localparam logic [3:0] STROBE_HIGH_CYC = 4'h2;
  localparam logic [3:0] READ_WAIT_CYC = 4'h3;

  typedef enum logic [3:0] {
    OP_READ, OP_RESET, OP_AUTOSEL_READ, OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE,
    OP_ABORT_RESET, OP_SUSPEND, OP_RESUME, OP_PSUSPEND, OP_PRESUME, OP_EXIT, OP_PWD_PROGRAM, OP_PWD_READ
  } fbc_op_t;

  typedef struct packed {
    fbc_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fbc_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] dout;
    logic doutEn;
    logic ceN;
    logic weN;
    logic oeN;
  } fbc_bus_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } fbc_cycle_t;
endpackage

// ===== fbc_cycle.sv
// One bus cycle (write or read) on the flash pins, built from clock counts.
`timescale 1ns/100ps
module fbc_cycle
  import fbc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Request
  input wire logic start,
  input wire logic isRead,
  input wire fbc_cycle_t cyc,
  // Pin input, already synchronised
  input wire logic [7:0] dinSync,
  // Result
  output logic done,
  output logic [7:0] rdData,
  output fbc_bus_t bus
);
  typedef enum logic [1:0] {C_IDLE, C_LOW, C_HIGH} fbc_cst_t;
  typedef struct packed {
    fbc_cst_t st;
    logic rd;
    logic [3:0] cnt;
    logic done;
    logic [7:0] rdData;
    fbc_bus_t bus;
  } fbc_cs_t;
  fbc_cs_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      C_IDLE: begin
        if (start) begin
          s_d.st = C_LOW;
          s_d.rd = isRead;
          s_d.bus.addr = cyc.addr;
          s_d.bus.dout = cyc.data;
          s_d.bus.doutEn = ~isRead;
          s_d.bus.ceN = 1'b0;
          s_d.bus.weN = isRead;
          s_d.bus.oeN = ~isRead;
          s_d.cnt = isRead ? READ_WAIT_CYC + 4'h2 : STROBE_LOW_CYC;
        end
      end
      C_LOW: begin
        if (s_q.cnt == 4'h0) begin
          if (s_q.rd) s_d.rdData = dinSync;
          s_d.bus.weN = 1'b1;
          s_d.bus.oeN = 1'b1;
          s_d.bus.ceN = 1'b1;
          s_d.st = C_HIGH;
          s_d.cnt = STROBE_HIGH_CYC;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      C_HIGH: begin
        if (s_q.cnt == 4'h0) begin
          s_d.bus.doutEn = 1'b0;
          s_d.st = C_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 4'h1;
        end
      end
      default: s_d.st = C_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= C_IDLE;
      s_q.bus.ceN <= 1'b1;
      s_q.bus.weN <= 1'b1;
      s_q.bus.oeN <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign done = s_q.done;
  assign rdData = s_q.rdData;
  assign bus = s_q.bus;
endmodule

// ===== fbc_host.sv
// Host controller issuing byte-mode command sequences to a parallel NOR flash.
`timescale 1ns/100ps
module fbc_host
  import fbc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // User command port
  input wire logic reqValid,
  input wire fbc_req_t req,
  output logic reqReady,
  output logic rspValid,
  output logic [7:0] rspData,
  output logic rspProtected,
  // Flash pins
  input wire logic [7:0] flashDin,
  output fbc_bus_t flashBus,
  output logic accelerateInput
);
  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT, H_DONE} fbc_hst_t;
  typedef struct packed {
    fbc_hst_t st;
    fbc_req_t req;
    logic [2:0] idx;
    logic [2:0] len;
    logic readyQ;
    logic rspValid;
    logic [7:0] rspData;
    logic rspProt;
    logic [7:0] din1, din2, din3;
    logic [7:0] dinStable;
    logic accel;
    logic start;
  } fbc_hs_t;
  fbc_hs_t s_q, s_d;
  fbc_cycle_t cyc;
  logic isRead;
  logic cycDone;
  logic [7:0] cycRd;
  fbc_bus_t bus;
  logic dinNew;

  fbc_cycle u_cycle (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(s_q.start),
    .isRead(isRead),
    .cyc(cyc),
    .dinSync(s_q.dinStable),
    .done(cycDone),
    .rdData(cycRd),
    .bus(bus)
  );

  // Number of bus cycles in each sequence; the last one is a read only for reads.
  function automatic logic [2:0] seqLen(input fbc_op_t op);
    unique case (op)
      OP_READ, OP_RESET, OP_SUSPEND, OP_RESUME, OP_PSUSPEND, OP_PRESUME: seqLen = 3'd1;
      OP_EXIT: seqLen = 3'd2;
      OP_ABORT_RESET: seqLen = 3'd3;
      OP_AUTOSEL_READ, OP_PROGRAM: seqLen = 3'd4;
      OP_PWD_READ: seqLen = 3'd4;
      OP_PWD_PROGRAM: seqLen = 3'd5;
      OP_SECTOR_ERASE, OP_CHIP_ERASE: seqLen = 3'd6;
      default: seqLen = 3'd1;
    endcase
  endfunction

  // Address and data for cycle idx of the stored sequence.
  always_comb begin
    cyc.addr = '0;
    cyc.data = 8'h00;
    isRead = 1'b0;
    unique case (s_q.req.op)
      OP_READ: begin
        cyc.addr = s_q.req.addr;
        isRead = 1'b1;
      end
      OP_RESET: cyc.data = CMD_RESET;
      OP_SUSPEND: cyc.data = CMD_SUSPEND;
      OP_RESUME: cyc.data = CMD_RESUME;
      OP_PSUSPEND: cyc.data = CMD_PSUSPEND;
      OP_PRESUME: cyc.data = CMD_PRESUME;
      OP_EXIT: cyc.data = (s_q.idx == 3'd0) ? CMD_AUTOSEL : CMD_EXIT;
      default: begin
        // Unlock prefix, repeated at cycles 3 and 4 of erase sequences.
        if (s_q.idx == 3'd0 || (s_q.idx == 3'd3 && s_q.len == 3'd6)) begin
          cyc.addr[11:0] = ADR_UNLOCK1;
          cyc.data = DAT_UNLOCK1;
        end else if (s_q.idx == 3'd1 || (s_q.idx == 3'd4 && s_q.len == 3'd6)) begin
          cyc.addr[11:0] = ADR_UNLOCK2;
          cyc.data = DAT_UNLOCK2;
        end else if (s_q.idx == 3'd2) begin
          cyc.addr[11:0] = ADR_UNLOCK1;
          unique case (s_q.req.op)
            OP_ABORT_RESET: cyc.data = CMD_RESET;
            OP_AUTOSEL_READ: cyc.data = CMD_AUTOSEL;
            OP_PROGRAM: cyc.data = CMD_PROGRAM;
            OP_PWD_PROGRAM, OP_PWD_READ: cyc.data = CMD_PWD_ENTRY;
            default: cyc.data = CMD_ERASE;
          endcase
        end else if (s_q.req.op == OP_AUTOSEL_READ) begin
          // Sector bits from the request, low byte is the query offset.
          cyc.addr = {s_q.req.addr[ADDR_W-1:8], s_q.req.data};
          isRead = 1'b1;
        end else if (s_q.req.op == OP_PWD_READ) begin
          // Upper bits are driven to zero, since the password words live in sector zero, word line zero.
          cyc.addr = {{(ADDR_W-2){1'b0}}, s_q.req.addr[1:0]};
          isRead = 1'b1;
        end else if (s_q.req.op == OP_PWD_PROGRAM && s_q.idx == 3'd3) begin
          cyc.data = CMD_PROGRAM;
        end else if (s_q.req.op == OP_PWD_PROGRAM) begin
          cyc.addr = {{(ADDR_W-2){1'b0}}, s_q.req.addr[1:0]};
          cyc.data = s_q.req.data;
        end else if (s_q.req.op == OP_PROGRAM) begin
          cyc.addr = s_q.req.addr;
          cyc.data = s_q.req.data;
        end else if (s_q.req.op == OP_SECTOR_ERASE) begin
          cyc.addr = s_q.req.addr;
          cyc.data = CMD_SECTOR;
        end else begin
          cyc.addr[11:0] = ADR_UNLOCK1;
          cyc.data = CMD_CHIP;
        end
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.din1 = flashDin;
    s_d.din2 = s_q.din1;
    s_d.din3 = s_q.din2;
    // A new pin value is only believed once the last two stages agree.
    if (!dinNew) s_d.dinStable = s_q.din3;
    s_d.accel = 1'b1;
    s_d.start = 1'b0;
    s_d.rspValid = 1'b0;
    s_d.readyQ = 1'b0;
    unique case (s_q.st)
      H_IDLE: begin
        s_d.readyQ = 1'b1;
        if (reqValid && s_q.readyQ) begin
          s_d.req = req;
          s_d.len = seqLen(req.op);
          s_d.idx = 3'd0;
          s_d.readyQ = 1'b0;
          s_d.st = H_ISSUE;
        end
      end
      H_ISSUE: begin
        s_d.start = 1'b1;
        s_d.st = H_WAIT;
      end
      H_WAIT: begin
        if (cycDone) begin
          if (s_q.idx == s_q.len - 3'd1) begin
            s_d.st = H_DONE;
          end else begin
            s_d.idx = s_q.idx + 3'd1;
            s_d.st = H_ISSUE;
          end
        end
      end
      H_DONE: begin
        s_d.rspValid = 1'b1;
        s_d.rspData = cycRd;
        // Autoselect answers 01 for a protected sector, status reads answer bit zero low.
        s_d.rspProt = (s_q.req.op == OP_AUTOSEL_READ) ? cycRd[0] : ~cycRd[0];
        s_d.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= H_IDLE;
      s_q.accel <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign dinNew = (s_q.din2 != s_q.din3);
  assign reqReady = s_q.readyQ;
  assign rspValid = s_q.rspValid;
  assign rspData = s_q.rspData;
  assign rspProtected = s_q.rspProt;
  assign flashBus = bus;
  assign accelerateInput = s_q.accel;

  sequence seqUnlock;
    s_q.start && cyc.data == DAT_UNLOCK1 && cyc.addr[11:0] == ADR_UNLOCK1 && s_q.idx != s_q.len - 3'd1;
  endsequence

  AST_UNLOCK_SECOND: assert property (@(posedge clk_sys) disable iff (reset)
    seqUnlock |-> ##[1:20] (s_q.start && cyc.data == DAT_UNLOCK2))
    else $error("second unlock cycle missing");
  AST_READ_NO_WE: assert property (@(posedge clk_sys) disable iff (reset)
    (!flashBus.oeN) |-> (flashBus.weN && !flashBus.doutEn))
    else $error("read drives write strobe or data");
  AST_PROT_BIT: assert property (@(posedge clk_sys) disable iff (reset)
    (rspValid && s_q.req.op != OP_AUTOSEL_READ) |-> rspProtected == ~rspData[0])
    else $error("protection flag mismatch");
  AST_PWD_ADDR: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.start && s_q.req.op == OP_PWD_PROGRAM && s_q.idx == 3'd4) |-> flashBus.addr[ADDR_W-1:2] == '0 ##1
      (flashBus.addr[ADDR_W-1:2] == '0 && !flashBus.weN))
    else $error("password word outside sector zero");
  AST_SINGLE_SUSPEND: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.st == H_ISSUE && s_q.req.op == OP_SUSPEND) |-> cyc.data == CMD_SUSPEND && s_q.len == 3'd1)
    else $error("suspend not a single write");
  AST_RESUME: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.st == H_ISSUE && s_q.req.op == OP_RESUME) |-> cyc.data == CMD_RESUME)
    else $error("resume data wrong");
  AST_PSUSPEND: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.st == H_ISSUE && s_q.req.op == OP_PSUSPEND) |-> cyc.data == CMD_PSUSPEND)
    else $error("program suspend data wrong");
  AST_PRESUME: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.st == H_ISSUE && s_q.req.op == OP_PRESUME) |-> cyc.data == CMD_PRESUME)
    else $error("program resume data wrong");
  AST_ERASE_LAST: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.st == H_ISSUE && s_q.idx == 3'd5 && s_q.req.op == OP_SECTOR_ERASE) |-> cyc.data == CMD_SECTOR)
    else $error("sector erase last cycle wrong");
  AST_ABORT: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.st == H_ISSUE && s_q.idx == 3'd2 && s_q.req.op == OP_ABORT_RESET) |-> cyc.data == CMD_RESET)
    else $error("abort reset command wrong");
  AST_RSP_AFTER_DONE: assert property (@(posedge clk_sys) disable iff (reset)
    (s_q.st == H_DONE) |=> rspValid ##1 reqReady)
    else $error("answer not given");
endmodule

// ===== fbc_flash_model.sv
// Behavioural byte-mode flash device that logs host writes and answers reads.
`timescale 1ns/100ps
module fbc_flash_model
  import fbc_pkg::*;
#(
  parameter logic [7:0] SECURE_LOCK = 8'h80
)
(
  // Flash pins
  input wire fbc_bus_t bus,
  output logic [7:0] dq
);
  logic [ADDR_W-1:0] logA[$];
  logic [7:0] logD[$];
  int badWr = 0;
  int stage = 0;
  logic autoMode = 1'b0;
  logic [7:0] lastOut = 8'h00;
  logic [7:0] rdVal;
  logic wrStrobe;
  logic wrArmed = 1'b0;
  logic pwdMode = 1'b0;
  logic pwdArm = 1'b0;
  logic [7:0] pwdMem[4] = '{default: 8'h00};

  // A write latches at whichever strobe rises first; the host may raise both together.
  assign wrStrobe = bus.weN | bus.ceN;

  // Arming on the falling strobe keeps the strobes settling out of reset from counting as a write.
  always @(negedge wrStrobe) wrArmed = 1'b1;

  // Command decoding looks at the low twelve address bits only; a password write checks the upper address bits are zero.
  always @(posedge wrStrobe) begin
    if (wrArmed) begin
      wrArmed = 1'b0;
      logA.push_back(bus.addr);
      logD.push_back(bus.dout);
      if (!bus.doutEn)
        badWr++;
      if (pwdArm) begin
        pwdArm = 1'b0;
        if (bus.addr[ADDR_W-1:2] == '0)
          pwdMem[bus.addr[1:0]] = bus.dout;
      end else if (bus.dout == CMD_RESET || bus.dout == CMD_EXIT) begin
        autoMode = 1'b0;
        pwdMode = 1'b0;
        stage = 0;
      end else if (stage == 0 && bus.addr[11:0] == ADR_UNLOCK1 && bus.dout == DAT_UNLOCK1)
        stage = 1;
      else if (stage == 1 && bus.addr[11:0] == ADR_UNLOCK2 && bus.dout == DAT_UNLOCK2)
        stage = 2;
      else begin
        if (stage == 2 && bus.dout == CMD_AUTOSEL)
          autoMode = 1'b1;
        if (stage == 2 && bus.dout == CMD_PWD_ENTRY)
          pwdMode = 1'b1;
        if (stage == 0 && pwdMode && bus.dout == CMD_PROGRAM)
          pwdArm = 1'b1;
        stage = 0;
      end
    end
  end

  // The low sector bit marks a protected sector, so at the protect offset any address inside the sector answers alike.
  always_comb begin
    if (pwdMode)
      rdVal = (bus.addr[ADDR_W-1:2] == '0) ? pwdMem[bus.addr[1:0]] : 8'hff;
    else if (!autoMode)
      rdVal = bus.addr[7:0] ^ 8'h5a;
    else if (bus.addr[7:0] == OFS_PROTECT)
      rdVal = {7'h00, bus.addr[16]};
    else if (bus.addr[7:0] == OFS_SECURE)
      rdVal = SECURE_LOCK;
    else
      rdVal = 8'h00;
  end

  // A released bus shows the inverse of the last byte, so stale data cannot pass for fresh.
  always @(posedge bus.oeN) lastOut = rdVal;
  assign dq = (!bus.ceN && !bus.oeN) ? rdVal : ~lastOut;
endmodule

// ===== fbc_host_test.sv
// Self-checking bench for the byte-mode flash command host.
`timescale 1ns/100ps
module fbc_host_test
  import fbc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic reqValid = 1'b0;
  fbc_req_t req = '0;
  logic reqReady, rspValid, rspProtected, accelerateInput, protSeen;
  logic [7:0] rspData, flashDin, rdByte;
  fbc_bus_t flashBus;
  int nErrors = 0;
  int numChecks = 0;
  int base = 0;

  always #25 clk_sys = ~clk_sys;

  fbc_host dut_u (.clk_sys(clk_sys), .reset(reset), .reqValid(reqValid), .req(req), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData), .rspProtected(rspProtected), .flashDin(flashDin),
    .flashBus(flashBus), .accelerateInput(accelerateInput));
  fbc_flash_model #(.SECURE_LOCK(8'h80)) model_u (.bus(flashBus), .dq(flashDin));

  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Called at a falling edge; the request stands until a rising edge finds the host ready.
  task automatic run(input fbc_op_t op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int i;
    base = model_u.logA.size();
    req = '{op: op, addr: a, data: d};
    reqValid = 1'b1;
    for (i = 0; i < 20 && reqReady !== 1'b1; i++)
      @(negedge clk_sys);
    @(negedge clk_sys);
    reqValid = 1'b0;
    for (i = 0; i < 300 && rspValid !== 1'b1; i++)
      @(negedge clk_sys);
    if (rspValid !== 1'b1) begin
      check("answer pulse", 1'b0, 1'b1);
      print_verdict();
    end else begin
      rdByte = rspData;
      protSeen = rspProtected;
      @(negedge clk_sys);
    end
  endtask

  task automatic cnt(input int n);
    check("write count", model_u.logA.size() - base, n);
  endtask

  task automatic wr(input int i, input logic [11:0] a, input logic [7:0] d);
    check("write address", model_u.logA[base + i][11:0], a);
    check("write data", model_u.logD[base + i], d);
  endtask

  task automatic t_read();
    run(OP_READ, 22'h012345, 8'h00);
    cnt(0);
    check("read byte", rdByte, 8'h1f);
    check("protect flag", protSeen, 1'b0);
    $display("test read done");
  endtask

  task automatic t_program();
    run(OP_PROGRAM, 22'h3f0123, 8'h3c);
    cnt(4);
    wr(0, ADR_UNLOCK1, DAT_UNLOCK1);
    wr(1, ADR_UNLOCK2, DAT_UNLOCK2);
    wr(2, ADR_UNLOCK1, CMD_PROGRAM);
    wr(3, 12'h123, 8'h3c);
    check("program location", model_u.logA[base + 3], 22'h3f0123);
    check("undriven writes", model_u.badWr, 0);
    $display("test program done");
  endtask

  task automatic erase6(input logic [11:0] a, input logic [7:0] d);
    cnt(6);
    wr(0, ADR_UNLOCK1, DAT_UNLOCK1);
    wr(1, ADR_UNLOCK2, DAT_UNLOCK2);
    wr(2, ADR_UNLOCK1, CMD_ERASE);
    wr(3, ADR_UNLOCK1, DAT_UNLOCK1);
    wr(4, ADR_UNLOCK2, DAT_UNLOCK2);
    wr(5, a, d);
  endtask

  task automatic t_erase();
    run(OP_SECTOR_ERASE, 22'h2a1234, 8'h00);
    erase6(12'h234, CMD_SECTOR);
    check("sector location", model_u.logA[base + 5], 22'h2a1234);
    run(OP_CHIP_ERASE, 22'h000000, 8'h00);
    erase6(ADR_UNLOCK1, CMD_CHIP);
    $display("test erase done");
  endtask

  task automatic t_autosel();
    logic [ADDR_W-1:0] adr[3] = '{22'h01ab00, 22'h02cd00, 22'h000000};
    logic [7:0] ofs[3] = '{OFS_PROTECT, OFS_PROTECT, OFS_SECURE};
    logic [7:0] expv[3] = '{8'h01, 8'h00, 8'h80};
    for (int i = 0; i < 3; i++) begin
      run(OP_AUTOSEL_READ, adr[i], ofs[i]);
      cnt(3);
      wr(2, ADR_UNLOCK1, CMD_AUTOSEL);
      check("autoselect byte", rdByte, expv[i]);
      check("protect flag", protSeen, expv[i][0]);
    end
    run(OP_RESET, 22'h000000, 8'h00);
    cnt(1);
    check("reset byte", model_u.logD[base], CMD_RESET);
    run(OP_READ, 22'h000077, 8'h00);
    check("array byte", rdByte, 8'h2d);
    $display("test autoselect done");
  endtask

  task automatic t_single();
    fbc_op_t ops[4] = '{OP_SUSPEND, OP_RESUME, OP_PSUSPEND, OP_PRESUME};
    logic [7:0] cmd[4] = '{CMD_SUSPEND, CMD_RESUME, CMD_PSUSPEND, CMD_PRESUME};
    for (int i = 0; i < 4; i++) begin
      run(ops[i], 22'h155555, 8'h00);
      cnt(1);
      check("command byte", model_u.logD[base], cmd[i]);
    end
    $display("test suspend done");
  endtask

  task automatic t_leave();
    run(OP_ABORT_RESET, 22'h000000, 8'h00);
    cnt(3);
    wr(0, ADR_UNLOCK1, DAT_UNLOCK1);
    wr(1, ADR_UNLOCK2, DAT_UNLOCK2);
    wr(2, ADR_UNLOCK1, CMD_RESET);
    run(OP_EXIT, 22'h000000, 8'h00);
    cnt(2);
    check("exit first", model_u.logD[base], CMD_AUTOSEL);
    check("exit second", model_u.logD[base + 1], CMD_EXIT);
    $display("test leave done");
  endtask

  task automatic t_password();
    run(OP_PWD_PROGRAM, 22'h000002, 8'hc5);
    cnt(5);
    wr(2, ADR_UNLOCK1, CMD_PWD_ENTRY);
    wr(3, 12'h000, CMD_PROGRAM);
    wr(4, 12'h002, 8'hc5);
    check("password location", model_u.logA[base + 4], 22'h000002);
    run(OP_PWD_READ, 22'h000002, 8'h00);
    cnt(3);
    check("password byte", rdByte, 8'hc5);
    run(OP_EXIT, 22'h000000, 8'h00);
    run(OP_READ, 22'h000002, 8'h00);
    check("array after exit", rdByte, 8'h58);
    $display("test password done");
  endtask

  initial begin
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    check("idle pins", {flashBus.ceN, flashBus.weN, flashBus.oeN, flashBus.doutEn}, 4'he);
    check("accelerate", accelerateInput, 1'b1);
    t_read();
    t_program();
    t_erase();
    t_autosel();
    t_single();
    t_leave();
    t_password();
    print_verdict();
  end
endmodule
